// File: src/wdg_consts.svh
// constants for the watchdog and halt/wake-up block
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

// ====================================================================
// register word indices (byte address is index times four)
`define WDG_IDX_INTERRUPT_CONTROL   6'h0b
`define WDG_IDX_WATCHDOG_SELECT   6'h0c
`define WDG_IDX_STAT   6'h0d
`define WDG_IDX_CFG    6'h0e
`define WDG_IDX_CMD    6'h0f

// ====================================================================
// interrupt_control fields
`define WDG_INTERRUPT_CONTROL_GEN   0
`define WDG_INTERRUPT_CONTROL_EEN   1
`define WDG_INTERRUPT_CONTROL_TEN   2
`define WDG_INTERRUPT_CONTROL_EFL   4
`define WDG_INTERRUPT_CONTROL_TFL   5
`define WDG_INTERRUPT_CONTROL_MASK  8'h37
`define WDG_INTERRUPT_CONTROL_RST   8'h00

// ====================================================================
// watchdog_select, status, config and command fields
`define WDG_WATCHDOG_SELECT_RST   8'h07
`define WDG_STAT_TO    0
`define WDG_STAT_PD    1
`define WDG_CFG_EN     0
`define WDG_CFG_SRC_RC 1
`define WDG_CFG_PAIR   2
`define WDG_CFG_OSC_RC 3
`define WDG_CFG_RST    16'h000b
`define WDG_CMD_CLR    0
`define WDG_CMD_CLR1   1
`define WDG_CMD_CLR2   2
`define WDG_CMD_HALT   3

// ====================================================================
// divider and timing
`define WDG_FIX_STAGES 8
`define WDG_PRE_STAGES 7
`define WDG_SYS_DIV    4
`define WDG_DUMMY_CYC  1024
`define WDG_RESP_OKAY  2'b00
`define WDG_RESP_SLV   2'b10

`endif

// File: src/wdg_pkg.sv
// types for the watchdog and halt/wake-up block
package wdg_pkg;
    typedef enum logic [1:0]
    {
        WDG_RUN   = 2'b00,
        WDG_HALT  = 2'b01,
        WDG_DUMMY = 2'b10
    } wdg_state_t;
endpackage

// File: src/wdg_divider.sv
// fixed divide-by-256 chain plus selectable prescaler
`timescale 1ns/1ps
`default_nettype none
`include "wdg_consts.svh"

module wdg_divider
#(
    parameter int FIX_W = `WDG_FIX_STAGES,
    parameter int PRE_W = `WDG_PRE_STAGES
)
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       clear,
    input  wire logic       tick,
    input  wire logic [2:0] sel,
    output logic            overflow
);
    localparam int CW = FIX_W + PRE_W;

    if (FIX_W < 1 || PRE_W < 7)
    begin : g_chk
        $error("wdg_divider: prescaler needs at least 7 stages");
    end

    // ones over the fixed stages plus the selected prescaler stages
    function automatic logic [CW-1:0] stage_mask(input logic [2:0] s);
        logic [CW-1:0] m;
        m = '0;
        for (int i = 0; i < CW; i++)
        begin
            if (i < FIX_W + int'(s))
            begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    wire  [CW-1:0] sel_mask = stage_mask(sel);

    // overflow when the 256 chain and the 1:2^n prescaler roll together
    assign overflow = tick && ((cnt_r & sel_mask) == sel_mask); // [RULE3] [RULE4] [RULE24]
    assign cnt_nxt  = (clear || overflow) ? '0 : (tick ? cnt_r + 1'b1 : cnt_r);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    property p_ovf_mask;
        @(posedge aclk) disable iff (!aresetn)
        overflow |-> (cnt_r[FIX_W-1:0] == '1) ##1 (cnt_r == '0);
    endproperty
    a_ovf_mask: assert property (p_ovf_mask) else $error("overflow before chain full"); // [RULE3]
endmodule
`default_nettype wire

// File: src/wdg_top.sv
// watchdog, halt and wake-up control with an AXI4-Lite register slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_consts.svh"

// How it works
// [RULE1] watchdog counts the RC oscillator or the instruction clock, by option
// [RULE2] option disables the watchdog; its commands then do nothing
// [RULE3] selected clock first passes a fixed divide-by-256 chain
// [RULE4] select bits 2..0 add a 1:2^n prescaler, 1:1 up to 1:128
// [RULE5] RC oscillator runs freely, also while halted
// [RULE6] instruction clock source stops counting during halt
// [RULE7] select bits 7..3 are plain user storage
// [RULE8] overflow in normal run gives a chip reset and sets time-out
// [RULE9] overflow in halt gives a warm reset of program counter and stack
// [RULE10] external reset, clear commands and halt clear counter and prescaler
// [RULE11] option picks one clear command or a pair of two distinct ones
// [RULE12] halt stops the system oscillator; RC oscillator keeps running
// [RULE13] during halt registers and state are held
// [RULE14] entering halt clears and restarts the watchdog
// [RULE15] halt sets power-down, clears time-out; clear and power-up clear power-down
// [RULE16] halt ends on external reset, interrupt, port fall or overflow
// [RULE17] each port bit is enabled for wake-up; resumes at next instruction
// [RULE18] interrupt wake vectors only when enabled and stack not full
// [RULE19] a flag already set at halt entry does not wake
// [RULE20] every wake-up waits 1024 system clocks before resuming; an external reset returns to run without the wait
// [RULE21] RC mode drives system clock divided by four on the oscillator pin
// [RULE22] interrupt control bits 0,1,2,4,5; bits 3,6,7 read zero
// [RULE23] time-out and power-down pair tells the reset cause
// [RULE24] overflow when divider chain and selected prescaler stage roll over
module wdg_top
    import wdg_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PORT_W = 8
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              dog_rc_clk,
    input  wire logic              ext_reset_n,
    input  wire logic              ext_irq_n,
    input  wire logic [PORT_W-1:0] port_a,
    input  wire logic              timer_ovf,
    input  wire logic              stack_full,
    output logic                   osc_out,
    output logic                   chip_reset,
    output logic                   warm_reset,
    output logic                   halted,
    output logic                   resume,
    output logic                   resume_vector
);
    localparam int SW = PORT_W + 3;
    localparam logic [9:0] DUMMY_LAST = 10'(`WDG_DUMMY_CYC - 1);
    localparam logic [1:0] DIV_LAST = 2'(`WDG_SYS_DIV - 1);

    if (ADDR_W < 8 || PORT_W < 1 || PORT_W > 8)
    begin : g_chk
        $error("wdg_top: ADDR_W must be >= 8 and PORT_W 1..8");
    end

    // word index of a mapped register, or 0 when unmapped
    function automatic logic [5:0] reg_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] hi;
        hi = a >> 8;
        if (hi != '0 || a[7:2] < `WDG_IDX_INTERRUPT_CONTROL || a[7:2] > `WDG_IDX_CMD)
            return 6'h00;
        return a[7:2];
    endfunction

    // ================================================================
    // pin synchronisers
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic [SW-1:0] prev_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= '1;
            sync2_r <= '1;
            prev_r  <= '1;
        end
        else
        begin
            sync1_r <= {dog_rc_clk, ext_reset_n, ext_irq_n, port_a};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    wire              rst_pin_n = sync2_r[PORT_W+1];
    wire              rc_tick   = sync2_r[PORT_W+2] && !prev_r[PORT_W+2];
    wire              ext_fall  = prev_r[PORT_W] && !sync2_r[PORT_W];
    wire [PORT_W-1:0] port_fall = prev_r[PORT_W-1:0] & ~sync2_r[PORT_W-1:0];

    // ================================================================
    // registers and state
    wdg_state_t state_r;
    wdg_state_t state_nxt;
    logic [7:0]  interrupt_control_r;
    logic [7:0]  watchdog_select_r;
    logic [15:0] cfg_r;
    logic        to_r;
    logic        pd_r;
    logic        first_r;
    logic        second_r;
    logic [1:0]  snap_r;
    logic        vec_r;
    logic [9:0]  dum_cnt_r;
    logic [1:0]  div4_r;

    wire cfg_en   = cfg_r[`WDG_CFG_EN];
    wire cfg_rc   = cfg_r[`WDG_CFG_SRC_RC];
    wire cfg_pair = cfg_r[`WDG_CFG_PAIR];
    wire [PORT_W-1:0] wake_mask = cfg_r[8 +: PORT_W];

    // ================================================================
    // AXI4-Lite slave
    logic              aw_got_r;
    logic              w_got_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire wr_go   = aw_got_r && w_got_r && !s_axi_bvalid;
    wire [5:0] wr_idx = reg_idx(awaddr_r);
    wire [5:0] rd_idx = reg_idx(s_axi_araddr);
    wire aw_got_nxt   = (aw_got_r || aw_fire) && !wr_go;
    wire w_got_nxt    = (w_got_r || w_fire) && !wr_go;
    wire rvalid_nxt   = ar_fire || (s_axi_rvalid && !s_axi_rready);

    // writes are held off while halted so state stays as it was
    wire we     = wr_go && wstrb_r[0] && (state_r == WDG_RUN); // [RULE13]
    wire we_interrupt_control = we && (wr_idx == `WDG_IDX_INTERRUPT_CONTROL);
    wire we_watchdog_select = we && (wr_idx == `WDG_IDX_WATCHDOG_SELECT);
    wire we_cfg  = wr_go && (wr_idx == `WDG_IDX_CFG) && (state_r == WDG_RUN);
    wire we_cmd  = we && (wr_idx == `WDG_IDX_CMD);

    wire [7:0] stat_rd = {6'h00, pd_r, to_r}; // [RULE23]
    wire [31:0] rd_mux =
        (rd_idx == `WDG_IDX_INTERRUPT_CONTROL) ? {24'h000000, interrupt_control_r & `WDG_INTERRUPT_CONTROL_MASK} : // [RULE22]
        (rd_idx == `WDG_IDX_WATCHDOG_SELECT) ? {24'h000000, watchdog_select_r} :
        (rd_idx == `WDG_IDX_STAT) ? {24'h000000, stat_rd} :
        (rd_idx == `WDG_IDX_CFG)  ? {16'h0000, cfg_r} : 32'h00000000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `WDG_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `WDG_RESP_OKAY;
        end
        else
        begin
            aw_got_r      <= aw_got_nxt;
            w_got_r       <= w_got_nxt;
            s_axi_awready <= !aw_got_nxt;
            s_axi_wready  <= !w_got_nxt;
            s_axi_arready <= !rvalid_nxt;
            s_axi_rvalid  <= rvalid_nxt;
            if (aw_fire)
                awaddr_r <= s_axi_awaddr;
            if (w_fire)
            begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_idx == 6'h00) ? `WDG_RESP_SLV : `WDG_RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (ar_fire)
            begin
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (rd_idx == 6'h00) ? `WDG_RESP_SLV : `WDG_RESP_OKAY;
            end
        end
    end

    // ================================================================
    // clear commands and watchdog clocking
    wire cmd_clr  = we_cmd && wdata_r[`WDG_CMD_CLR];
    wire cmd_clr1 = we_cmd && wdata_r[`WDG_CMD_CLR1];
    wire cmd_clr2 = we_cmd && wdata_r[`WDG_CMD_CLR2];
    wire halt_go  = we_cmd && wdata_r[`WDG_CMD_HALT] && rst_pin_n;
    wire pair_seen1 = first_r || cmd_clr1;
    wire pair_seen2 = second_r || cmd_clr2;
    wire pair_done  = pair_seen1 && pair_seen2;
    wire clr_eff = cfg_en && (cfg_pair ? pair_done : cmd_clr); // [RULE2] [RULE11]

    // instruction clock stops with the system oscillator in halt
    wire sys_run    = (state_r != WDG_HALT); // [RULE12]
    wire instr_tick = sys_run && (div4_r == DIV_LAST);
    wire dog_tick   = cfg_en && (cfg_rc ? rc_tick : instr_tick); // [RULE1] [RULE5] [RULE6]
    logic dog_ovf;
    wire ovf_run  = dog_ovf && (state_r == WDG_RUN);
    wire ovf_halt = dog_ovf && (state_r == WDG_HALT);
    wire dog_clear = !rst_pin_n || clr_eff || halt_go || ovf_run; // [RULE10] [RULE14]

    wdg_divider u_div
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (dog_clear),
        .tick     (dog_tick),
        .sel      (watchdog_select_r[2:0]),
        .overflow (dog_ovf)
    );

    // ================================================================
    // halt and wake-up sequencing
    wire [1:0] flags    = {interrupt_control_r[`WDG_INTERRUPT_CONTROL_TFL], interrupt_control_r[`WDG_INTERRUPT_CONTROL_EFL]};
    wire [1:0] ens      = {interrupt_control_r[`WDG_INTERRUPT_CONTROL_TEN], interrupt_control_r[`WDG_INTERRUPT_CONTROL_EEN]};
    wire [1:0] new_fl   = flags & ~snap_r; // [RULE19]
    wire wake_irq  = |new_fl;
    wire wake_port = |(port_fall & wake_mask); // [RULE17]
    wire wake_vec  = wake_irq && interrupt_control_r[`WDG_INTERRUPT_CONTROL_GEN] && |(new_fl & ens) && !stack_full;
    wire dum_last  = (state_r == WDG_DUMMY) && (dum_cnt_r == DUMMY_LAST);
    wire full_rst  = !rst_pin_n || ovf_run;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            WDG_RUN:
                if (halt_go)
                    state_nxt = WDG_HALT;
            WDG_HALT:
                if (!rst_pin_n)
                    state_nxt = WDG_RUN; // [RULE16]
                else if (ovf_halt || wake_port || wake_irq)
                    state_nxt = WDG_DUMMY; // [RULE16]
            WDG_DUMMY:
                if (!rst_pin_n || dum_last)
                    state_nxt = WDG_RUN; // [RULE20]
            default:
                state_nxt = WDG_RUN;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r   <= WDG_RUN;
            dum_cnt_r <= 10'h000;
            div4_r    <= 2'h0;
            snap_r    <= 2'h0;
            vec_r     <= 1'b0;
            first_r   <= 1'b0;
            second_r  <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            dum_cnt_r <= (state_r == WDG_DUMMY) ? dum_cnt_r + 10'h001 : 10'h000; // [RULE20]
            div4_r    <= sys_run ? div4_r + 2'h1 : div4_r;
            if (halt_go)
                snap_r <= flags; // [RULE19]
            if (state_r == WDG_HALT)
                vec_r <= wake_vec && !wake_port && !ovf_halt; // [RULE18]
            first_r   <= cfg_pair && !pair_done && !full_rst && pair_seen1; // [RULE11]
            second_r  <= cfg_pair && !pair_done && !full_rst && pair_seen2; // [RULE11]
        end
    end

    // ================================================================
    // user registers and status flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            interrupt_control_r <= `WDG_INTERRUPT_CONTROL_RST;
            watchdog_select_r <= `WDG_WATCHDOG_SELECT_RST;
            cfg_r  <= `WDG_CFG_RST;
            to_r   <= 1'b0; // [RULE15] [RULE23]
            pd_r   <= 1'b0; // [RULE15] [RULE23]
        end
        else
        begin
            if (full_rst)
            begin
                interrupt_control_r <= `WDG_INTERRUPT_CONTROL_RST;
                watchdog_select_r <= `WDG_WATCHDOG_SELECT_RST;
            end
            else
            begin
                if (we_interrupt_control)
                    interrupt_control_r <= wdata_r[7:0] & `WDG_INTERRUPT_CONTROL_MASK; // [RULE22]
                if (ext_fall)
                    interrupt_control_r[`WDG_INTERRUPT_CONTROL_EFL] <= 1'b1;
                if (timer_ovf)
                    interrupt_control_r[`WDG_INTERRUPT_CONTROL_TFL] <= 1'b1;
                if (we_watchdog_select)
                    watchdog_select_r <= wdata_r[7:0]; // [RULE7]
            end
            if (we_cfg && wstrb_r[0])
                cfg_r[7:0] <= wdata_r[7:0];
            if (we_cfg && wstrb_r[1])
                cfg_r[15:8] <= wdata_r[15:8];
            // overflow wins over any clear in the same cycle
            if (dog_ovf)
                to_r <= 1'b1; // [RULE8] [RULE23]
            else if (halt_go || clr_eff)
                to_r <= 1'b0; // [RULE15]
            if (halt_go)
                pd_r <= 1'b1; // [RULE15]
            else if (clr_eff)
                pd_r <= 1'b0; // [RULE15]
        end
    end

    // ================================================================
    // outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osc_out       <= 1'b0;
            chip_reset    <= 1'b0;
            warm_reset    <= 1'b0;
            halted        <= 1'b0;
            resume        <= 1'b0;
            resume_vector <= 1'b0;
        end
        else
        begin
            osc_out       <= cfg_r[`WDG_CFG_OSC_RC] && div4_r[1]; // [RULE21]
            chip_reset    <= full_rst; // [RULE8] [RULE10]
            warm_reset    <= ovf_halt; // [RULE9]
            halted        <= (state_nxt != WDG_RUN); // [RULE13]
            resume        <= dum_last; // [RULE20]
            resume_vector <= dum_last && vec_r; // [RULE18]
        end
    end

    // ================================================================
    // checks
    logic [10:0] dchk_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dchk_r <= 11'h000;
        else
            dchk_r <= (state_r == WDG_DUMMY) ? dchk_r + 11'h001 : 11'h000;
    end

    property p_dummy_len;
        @(posedge aclk) disable iff (!aresetn)
        $rose(resume) |-> ($past(dchk_r) == 11'd1023) && (state_r == WDG_RUN);
    endproperty
    a_dummy_len: assert property (p_dummy_len) else $error("dummy period not 1024"); // [RULE20]

    property p_halt_flags;
        @(posedge aclk) disable iff (!aresetn)
        (halt_go && !dog_ovf) |=> pd_r && !to_r && halted && (state_r == WDG_HALT);
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong"); // [RULE15]

    property p_run_ovf;
        @(posedge aclk) disable iff (!aresetn)
        ovf_run |=> chip_reset && to_r ##1 (watchdog_select_r == `WDG_WATCHDOG_SELECT_RST);
    endproperty
    a_run_ovf: assert property (p_run_ovf) else $error("overflow did not reset"); // [RULE8]

    property p_warm;
        @(posedge aclk) disable iff (!aresetn)
        (ovf_halt && rst_pin_n) |=> warm_reset && !chip_reset && to_r && pd_r;
    endproperty
    a_warm: assert property (p_warm) else $error("halt overflow not warm"); // [RULE9]

    property p_disabled;
        @(posedge aclk) disable iff (!aresetn)
        !cfg_en |-> !dog_ovf && !clr_eff;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled dog acted"); // [RULE2]

    property p_stop_halt;
        @(posedge aclk) disable iff (!aresetn)
        (state_r == WDG_HALT && !cfg_rc) |-> !dog_tick;
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("instr clock ran in halt"); // [RULE6]

    property p_port_wake;
        @(posedge aclk) disable iff (!aresetn)
        (state_r == WDG_HALT && rst_pin_n && wake_port) |=> (state_r == WDG_DUMMY) [*2];
    endproperty
    a_port_wake: assert property (p_port_wake) else $error("port wake missed"); // [RULE17]

    property p_stale_flag;
        @(posedge aclk) disable iff (!aresetn)
        (state_r == WDG_HALT && rst_pin_n && !dog_ovf && !wake_port && flags == snap_r)
            |=> (state_r == WDG_HALT);
    endproperty
    a_stale_flag: assert property (p_stale_flag) else $error("stale flag woke"); // [RULE19]

    property p_interrupt_control_zero;
        @(posedge aclk) disable iff (!aresetn)
        (ar_fire && rd_idx == `WDG_IDX_INTERRUPT_CONTROL) |=> (s_axi_rdata[7:6] == 2'b00) && !s_axi_rdata[3];
    endproperty
    a_interrupt_control_zero: assert property (p_interrupt_control_zero) else $error("interrupt_control unused bits set"); // [RULE22]

    property p_osc_stop;
        @(posedge aclk) disable iff (!aresetn)
        (state_r == WDG_HALT) [*3] |-> $stable(osc_out);
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("osc pin ran in halt"); // [RULE12]
endmodule
`default_nettype wire

// File: tb/wdg_pin_model.sv
// pin-side model: free-running watchdog rc oscillator and port a
`timescale 1ns/1ps
`default_nettype none
module wdg_pin_model
(
    input  wire logic       pa_fall,
    output logic            dog_rc_clk,
    output logic [7:0]      port_a
);
    initial
    begin
        dog_rc_clk = 1'b0;
        // phase offset keeps the rc edges off both aclk edges
        #7;
        forever #365 dog_rc_clk = ~dog_rc_clk;
    end
    // bit 0 pulled low on request, others idle high
    assign port_a = pa_fall ? 8'hfe : 8'hff;
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the watchdog and halt block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk, aresetn, awvalid, wvalid, arvalid, bready, rready, timer_ovf, pa_fall;
    logic awready, wready, arready, bvalid, rvalid, rc, osc_out, chip_reset;
    logic warm_reset, halted, resume, resume_vector, xrst_n, xirq_n;
    logic [7:0] awaddr, araddr, pa;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int fails, check_count, cyc, n;
    wdg_top DUT (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .dog_rc_clk(rc), .ext_reset_n(xrst_n), .ext_irq_n(xirq_n), .port_a(pa),
        .timer_ovf, .stack_full(1'b0), .osc_out, .chip_reset, .warm_reset,
        .halted, .resume, .resume_vector);
    wdg_pin_model PM (.pa_fall, .dog_rc_clk(rc), .port_a(pa));
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fails++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // bready and rready stay high for the whole run
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (!ad && awready === 1'b1)
            begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1)
            begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("bresp", er, bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk("rresp", er, rresp);
        if (er == 2'b00)
            chk("rdata", e, rdata);
    endtask
    // cycles until a selected pulse: bit2 chip_reset, bit1 warm_reset, bit0 resume
    task automatic wt(input logic [2:0] m);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (({chip_reset, warm_reset, resume} & m) === 3'b000);
    endtask
    task automatic tick_timer();
        @(posedge aclk);
        timer_ovf <= 1'b1;
        @(posedge aclk);
        timer_ovf <= 1'b0;
    endtask
    task automatic t_regs();
        logic p;
        rd(8'h2c, 32'h0, 2'b00);
        rd(8'h30, 32'h7, 2'b00);
        rd(8'h34, 32'h0, 2'b00);
        rd(8'h38, 32'hb, 2'b00);
        rd(8'hfc, 32'h0, 2'b10);
        wr(8'hfc, 32'h0, 2'b10);
        wr(8'h30, 32'hf8, 2'b00);
        rd(8'h30, 32'hf8, 2'b00);
        wr(8'h2c, 32'hff, 2'b00);
        rd(8'h2c, 32'h37, 2'b00);
        wr(8'h2c, 32'h0, 2'b00);
        xirq_n <= 1'b0;
        wr(8'h34, 32'h3, 2'b00);
        rd(8'h34, 32'h0, 2'b00);
        rd(8'h2c, 32'h10, 2'b00);
        p = osc_out;
        n = 0;
        repeat (40)
        begin
            @(posedge aclk);
            if (osc_out === 1'b1 && p === 1'b0)
                n++;
            p = osc_out;
        end
        chk("osc rises", 10, n);
    endtask
    task automatic t_halt();
        wr(8'h38, 32'h010b, 2'b00);
        wr(8'h3c, 32'h8, 2'b00);
        chk("halted", 1, halted);
        rd(8'h34, 32'h2, 2'b00);
        pa_fall <= 1'b1;
        wt(3'b001);
        chk("port wake delay", 1, n >= 1024 && n <= 1036);
        chk("port vector", 0, resume_vector);
        pa_fall <= 1'b0;
        wr(8'h3c, 32'h1, 2'b00);
        rd(8'h34, 32'h0, 2'b00);
    endtask
    task automatic t_pair();
        wr(8'h2c, 32'h5, 2'b00);
        wr(8'h38, 32'h7, 2'b00);
        wr(8'h3c, 32'h8, 2'b00);
        tick_timer();
        wt(3'b001);
        chk("irq vector", 1, resume_vector);
        wr(8'h3c, 32'h1, 2'b00);
        rd(8'h34, 32'h2, 2'b00);
        wr(8'h3c, 32'h6, 2'b00);
        rd(8'h34, 32'h0, 2'b00);
    endtask
    // timer flag is still set from before, so only the watchdog wakes
    task automatic t_warm();
        wr(8'h3c, 32'h8, 2'b00);
        tick_timer();
        wt(3'b011);
        chk("warm first", 1, warm_reset);
        chk("halt ovf time", 1, n >= 1830 && n <= 1890);
        wt(3'b001);
        rd(8'h34, 32'h3, 2'b00);
    endtask
    task automatic t_run();
        wr(8'h38, 32'h1, 2'b00);
        wr(8'h3c, 32'h1, 2'b00);
        wt(3'b100);
        chk("run ovf time", 1, n >= 1012 && n <= 1030);
        rd(8'h34, 32'h1, 2'b00);
        rd(8'h30, 32'h7, 2'b00);
    endtask
    task automatic t_off();
        wr(8'h30, 32'hf8, 2'b00);
        wr(8'h38, 32'h0, 2'b00);
        wr(8'h3c, 32'h1, 2'b00);
        n = 0;
        repeat (1300)
        begin
            @(posedge aclk);
            if (chip_reset !== 1'b0)
                n++;
        end
        chk("disabled reset", 0, n);
    endtask
    // external reset pin ends halt at once and leaves the time-out and power-down flags alone
    task automatic t_ext();
        wr(8'h3c, 32'h8, 2'b00);
        xrst_n <= 1'b0;
        wt(3'b100);
        chk("ext halt end", 0, halted);
        xrst_n <= 1'b1;
        rd(8'h34, 32'h2, 2'b00);
        rd(8'h30, 32'h7, 2'b00);
    endtask
    initial
    begin
        {awvalid, wvalid, arvalid, timer_ovf, pa_fall, aresetn} = 6'h00;
        {bready, rready, xrst_n, xirq_n} = 4'hf;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'h3;
        {fails, check_count, cyc} = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_halt();
        t_pair();
        t_warm();
        t_run();
        t_off();
        t_ext();
        conclude();
    end
endmodule
`default_nettype wire
